/* File: core/serial_port_defs.svh */
// Constants for the serial configuration port.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

`define SP_PORT_SERIAL    1'b1
`define SP_MODE_FRAME     1'b1
`define SP_MSB_FIRST      1'b1
`define SP_RW_BIT         7
`define SP_RW_READ        1'b1
`define SP_COUNT_MSB      6
`define SP_COUNT_ONE      7'h01
`define SP_COUNT_ZERO     7'h00
`define SP_LAST_BIT       3'h7
`define SP_FIRST_BIT      3'h0
`define SP_ADDR_RST       8'h00
`define SP_BYTE_RST       8'h00
`define SP_ADDR_STEP      8'h01

`endif

/* File: core/serial_port_pkg.sv */
// Types and helpers shared by the serial configuration port modules.
`default_nettype none
package serial_port_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [6:0] count_t;

    typedef enum logic [2:0] {
        ST_ADDR,
        ST_INSTR,
        ST_WRITE,
        ST_FETCH,
        ST_LOAD,
        ST_READ
    } txn_state_e;

    // Moves one bit into a byte from the side that matches the bit order.
    function automatic byte_t shift_in(input byte_t cur, input logic bit_in,
                                       input logic msb_first);
        shift_in = msb_first ? {cur[6:0], bit_in} : {bit_in, cur[7:1]};
    endfunction : shift_in

endpackage : serial_port_pkg
`default_nettype wire

/* File: core/byte_link_if.sv */
// Byte hand-over between the serial clock side and the core clock side.
`default_nettype none
interface byte_link_if;
    serial_port_pkg::byte_t rx_hold0;
    serial_port_pkg::byte_t rx_hold1;
    logic                   rx_tgl;
    serial_port_pkg::byte_t tx_byte;
    logic                   tx_tgl;

    modport link (output rx_hold0, output rx_hold1, output rx_tgl,
                  input tx_byte, input tx_tgl);
    modport core (input rx_hold0, input rx_hold1, input rx_tgl,
                  output tx_byte, output tx_tgl);
endinterface : byte_link_if
`default_nettype wire

/* File: core/bit_sync.sv */
// Two flip-flop level synchroniser.
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule : bit_sync
`default_nettype wire

/* File: core/serial_shifter.sv */
// Serial clock side: bit framing, byte assembly and open-drain read shifting.
`default_nettype none
`include "serial_port_defs.svh"
module serial_shifter (
    input  wire logic  serial_clock,
    input  wire logic  reset_n,
    input  wire logic  serial_select_n,
    input  wire logic  serial_in_pin,
    input  wire logic  receive_frame_sync,
    input  wire logic  transmit_frame_sync,
    input  wire logic  serial_mode,
    input  wire logic  msb_first,
    output logic       serial_out_oe,
    byte_link_if.link  lnk
);
    logic                   frame_mode;
    logic                   msb;
    logic                   link_clr_n;
    logic                   rfs_ff;
    logic                   tfs_ff;
    logic                   start;
    logic                   bit_on;
    logic [2:0]             cnt_ff,   nxt_cnt;
    serial_port_pkg::byte_t shin_ff,  nxt_shin;
    serial_port_pkg::byte_t shout_ff, nxt_shout;
    logic                   drive_ff, nxt_drive;
    logic                   oe_ff,    nxt_oe;
    logic                   ack_ff,   nxt_ack;
    serial_port_pkg::byte_t h0_ff,    nxt_h0;
    serial_port_pkg::byte_t h1_ff,    nxt_h1;
    logic                   tgl_ff,   nxt_tgl;

    // The strap pins and the hand-over toggle settle while the host's clock is stopped,
    // so a byte's first edge reads them directly; a synchroniser would need edges that
    // a select-framed host never gives between the instruction and the read byte.
    assign frame_mode = (serial_mode == `SP_MODE_FRAME);
    assign msb        = (msb_first == `SP_MSB_FIRST);
    // A high select clears any half-shifted byte; a stopped clock cannot do it.
    assign link_clr_n = reset_n & ~serial_select_n;

    always_ff @(negedge serial_clock or negedge link_clr_n) begin
        if (!link_clr_n) begin
            rfs_ff <= 1'b0;
            tfs_ff <= 1'b0;
        end else begin
            rfs_ff <= receive_frame_sync;
            tfs_ff <= transmit_frame_sync;
        end
    end

    assign start  = (cnt_ff == `SP_FIRST_BIT) && (!frame_mode || rfs_ff || tfs_ff);
    assign bit_on = (cnt_ff != `SP_FIRST_BIT) || start;

    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_shin  = shin_ff;
        nxt_shout = shout_ff;
        nxt_drive = 1'b0;
        nxt_ack   = ack_ff;
        nxt_h0    = h0_ff;
        nxt_h1    = h1_ff;
        nxt_tgl   = tgl_ff;
        if (bit_on) begin
            nxt_shin = serial_port_pkg::shift_in(shin_ff, serial_in_pin, msb);
            if (cnt_ff == `SP_LAST_BIT) begin
                nxt_cnt = `SP_FIRST_BIT;
                if (tgl_ff) nxt_h1 = nxt_shin;
                else        nxt_h0 = nxt_shin;
                nxt_tgl = ~tgl_ff;
            end else begin
                nxt_cnt = cnt_ff + 3'h1;
            end
            if (start) begin
                if ((lnk.tx_tgl != ack_ff) && (!frame_mode || tfs_ff)) begin
                    nxt_shout = lnk.tx_byte;
                    nxt_ack   = lnk.tx_tgl;
                    nxt_drive = 1'b1;
                end
            end else begin
                nxt_shout = msb ? {shout_ff[6:0], 1'b0} : {1'b0, shout_ff[7:1]};
                nxt_drive = drive_ff;
            end
        end
        // Open drain: the pin is only ever pulled low, never driven high.
        nxt_oe = nxt_drive & ~(msb ? nxt_shout[7] : nxt_shout[0]);
    end

    always_ff @(posedge serial_clock or negedge link_clr_n) begin
        if (!link_clr_n) begin
            cnt_ff   <= `SP_FIRST_BIT;
            shin_ff  <= `SP_BYTE_RST;
            shout_ff <= `SP_BYTE_RST;
            drive_ff <= 1'b0;
            oe_ff    <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            shin_ff  <= nxt_shin;
            shout_ff <= nxt_shout;
            drive_ff <= nxt_drive;
            oe_ff    <= nxt_oe;
        end
    end

    // Hand-over state survives select so that both sides keep their toggles aligned.
    always_ff @(posedge serial_clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
            h0_ff  <= `SP_BYTE_RST;
            h1_ff  <= `SP_BYTE_RST;
            tgl_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
            h0_ff  <= nxt_h0;
            h1_ff  <= nxt_h1;
            tgl_ff <= nxt_tgl;
        end
    end

    assign serial_out_oe = oe_ff;
    assign lnk.rx_hold0  = h0_ff;
    assign lnk.rx_hold1  = h1_ff;
    assign lnk.rx_tgl    = tgl_ff;
endmodule : serial_shifter
`default_nettype wire

/* File: core/serial_config_port.sv */
// Serial configuration port top: transaction sequencing and register access.
`default_nettype none
`include "serial_port_defs.svh"
module serial_config_port (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       serial_clock,
    input  wire logic       serial_select_n,
    input  wire logic       serial_in_pin,
    input  wire logic       receive_frame_sync,
    input  wire logic       transmit_frame_sync,
    input  wire logic       config_port_select,
    input  wire logic       serial_mode,
    input  wire logic       msb_first,
    input  wire logic [7:0] reg_rdata,
    output logic            serial_out_pin_o,
    output logic            serial_out_pin_oe,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_write,
    output logic            reg_read,
    output logic            serial_active,
    output logic            transfer_busy,
    output logic            format_error
);
    byte_link_if lnk ();

    logic [1:0]                  pin_q;
    logic                        rx_q;
    logic                        port_on;
    logic                        down;
    logic                        rx_event;
    serial_port_pkg::byte_t      rx_byte;
    serial_port_pkg::byte_t      stepped;
    logic                        seen_ff,  nxt_seen;
    logic                        par_ff,   nxt_par;
    serial_port_pkg::txn_state_e state_ff, nxt_state;
    serial_port_pkg::byte_t      addr_ff,  nxt_addr;
    serial_port_pkg::count_t     count_ff, nxt_count;
    serial_port_pkg::byte_t      raddr_ff, nxt_raddr;
    serial_port_pkg::byte_t      wdata_ff, nxt_wdata;
    logic                        write_ff, nxt_write;
    logic                        read_ff,  nxt_read;
    serial_port_pkg::byte_t      tx_ff,    nxt_tx;
    logic                        txt_ff,   nxt_txt;
    logic                        active_ff, nxt_active;
    logic                        busy_ff,  nxt_busy;
    logic                        err_ff,   nxt_err;

    // Static strap-like pins are synchronised before the sequencer looks at them.
    bit_sync #(.WIDTH(2)) u_pin_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .d       ({config_port_select, msb_first}),
        .q       (pin_q)
    );

    bit_sync #(.WIDTH(1)) u_rx_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .d       (lnk.rx_tgl),
        .q       (rx_q)
    );

    serial_shifter u_shifter (
        .serial_clock        (serial_clock),
        .reset_n             (reset_n),
        .serial_select_n     (serial_select_n),
        .serial_in_pin       (serial_in_pin),
        .receive_frame_sync  (receive_frame_sync),
        .transmit_frame_sync (transmit_frame_sync),
        .serial_mode         (serial_mode),
        .msb_first           (msb_first),
        .serial_out_oe       (serial_out_pin_oe),
        .lnk                 (lnk.link)
    );

    assign port_on  = (pin_q[1] == `SP_PORT_SERIAL);
    assign down     = (pin_q[0] == `SP_MSB_FIRST);
    assign rx_event = rx_q ^ seen_ff;
    // Two hold registers alternate, so a byte stays stable for a full byte time.
    assign rx_byte  = par_ff ? lnk.rx_hold1 : lnk.rx_hold0;
    // Decrement walks down from the top of the block, increment walks up.
    assign stepped  = down ? (addr_ff - `SP_ADDR_STEP)
                           : (addr_ff + `SP_ADDR_STEP);

    always_comb begin
        nxt_seen   = rx_q;
        nxt_par    = par_ff ^ rx_event;
        nxt_state  = state_ff;
        nxt_addr   = addr_ff;
        nxt_count  = count_ff;
        nxt_raddr  = raddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_write  = 1'b0;
        nxt_read   = 1'b0;
        nxt_tx     = tx_ff;
        nxt_txt    = txt_ff;
        nxt_err    = err_ff;
        nxt_active = port_on;
        if (!port_on) begin
            nxt_state = serial_port_pkg::ST_ADDR;
        end else begin
            case (state_ff)
                serial_port_pkg::ST_ADDR: begin
                    if (rx_event) begin
                        nxt_addr  = rx_byte;
                        nxt_err   = 1'b0;
                        nxt_state = serial_port_pkg::ST_INSTR;
                    end
                end
                serial_port_pkg::ST_INSTR: begin
                    if (rx_event) begin
                        // A seven-bit field cannot exceed the block limit of 127.
                        nxt_count = rx_byte[`SP_COUNT_MSB:0];
                        if (rx_byte[`SP_COUNT_MSB:0] == `SP_COUNT_ZERO) begin
                            nxt_err   = 1'b1;
                            nxt_state = serial_port_pkg::ST_ADDR;
                        end else if (rx_byte[`SP_RW_BIT] == `SP_RW_READ) begin
                            nxt_state = serial_port_pkg::ST_FETCH;
                        end else begin
                            nxt_state = serial_port_pkg::ST_WRITE;
                        end
                    end
                end
                serial_port_pkg::ST_WRITE: begin
                    if (rx_event) begin
                        nxt_raddr = addr_ff;
                        nxt_wdata = rx_byte;
                        nxt_write = 1'b1;
                        nxt_addr  = stepped;
                        nxt_count = count_ff - `SP_COUNT_ONE;
                        if (count_ff == `SP_COUNT_ONE) begin
                            nxt_state = serial_port_pkg::ST_ADDR;
                        end
                    end
                end
                serial_port_pkg::ST_FETCH: begin
                    nxt_raddr = addr_ff;
                    nxt_read  = 1'b1;
                    nxt_state = serial_port_pkg::ST_LOAD;
                    if (rx_event) begin
                        nxt_err = 1'b1;
                    end
                end
                serial_port_pkg::ST_LOAD: begin
                    nxt_tx    = reg_rdata;
                    nxt_txt   = ~txt_ff;
                    nxt_state = serial_port_pkg::ST_READ;
                    if (rx_event) begin
                        nxt_err = 1'b1;
                    end
                end
                serial_port_pkg::ST_READ: begin
                    // The byte boundary after loading marks the read byte as shifted out.
                    if (rx_event) begin
                        nxt_addr  = stepped;
                        nxt_count = count_ff - `SP_COUNT_ONE;
                        if (count_ff == `SP_COUNT_ONE) begin
                            nxt_state = serial_port_pkg::ST_ADDR;
                        end else begin
                            nxt_state = serial_port_pkg::ST_FETCH;
                        end
                    end
                end
                default: begin
                    nxt_state = serial_port_pkg::ST_ADDR;
                end
            endcase
        end
        nxt_busy = (nxt_state != serial_port_pkg::ST_ADDR);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            seen_ff   <= 1'b0;
            par_ff    <= 1'b0;
            state_ff  <= serial_port_pkg::ST_ADDR;
            addr_ff   <= `SP_ADDR_RST;
            count_ff  <= `SP_COUNT_ZERO;
            raddr_ff  <= `SP_ADDR_RST;
            wdata_ff  <= `SP_BYTE_RST;
            write_ff  <= 1'b0;
            read_ff   <= 1'b0;
            tx_ff     <= `SP_BYTE_RST;
            txt_ff    <= 1'b0;
            active_ff <= 1'b0;
            busy_ff   <= 1'b0;
            err_ff    <= 1'b0;
        end else begin
            seen_ff   <= nxt_seen;
            par_ff    <= nxt_par;
            state_ff  <= nxt_state;
            addr_ff   <= nxt_addr;
            count_ff  <= nxt_count;
            raddr_ff  <= nxt_raddr;
            wdata_ff  <= nxt_wdata;
            write_ff  <= nxt_write;
            read_ff   <= nxt_read;
            tx_ff     <= nxt_tx;
            txt_ff    <= nxt_txt;
            active_ff <= nxt_active;
            busy_ff   <= nxt_busy;
            err_ff    <= nxt_err;
        end
    end

    assign lnk.tx_byte      = tx_ff;
    assign lnk.tx_tgl       = txt_ff;
    // The pin is open drain, so its driven level is always low.
    assign serial_out_pin_o = 1'b0;
    assign reg_addr         = raddr_ff;
    assign reg_wdata        = wdata_ff;
    assign reg_write        = write_ff;
    assign reg_read         = read_ff;
    assign serial_active    = active_ff;
    assign transfer_busy    = busy_ff;
    assign format_error     = err_ff;
endmodule : serial_config_port
`default_nettype wire

/* File: tb/serial_config_port_properties.sv */
// Concurrent checks on the serial configuration port's top-level ports.
`default_nettype none
module port_rules (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       config_port_select,
    input wire logic       serial_select_n,
    input wire logic       msb_first,
    input wire logic       serial_out_pin_o,
    input wire logic       serial_out_pin_oe,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic       serial_active,
    input wire logic       transfer_busy,
    input wire logic       format_error
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_ff;
    logic [7:0] nxt_last;
    logic       seen_ff;
    logic       nxt_seen;
    // The step check needs the previous access of the same block, so the flag clears
    // once the port is no longer busy with a block.
    always_comb begin
        nxt_last = (reg_write || reg_read) ? reg_addr : last_ff;
        nxt_seen = transfer_busy && (seen_ff || reg_write || reg_read);
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            last_ff <= 8'h00;
            seen_ff <= 1'b0;
        end else begin
            last_ff <= nxt_last;
            seen_ff <= nxt_seen;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    property p_open_drain;
        serial_out_pin_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("Serial data output driven high.");
    property p_active;
        $stable(config_port_select) [*5] |-> serial_active == config_port_select;
    endproperty
    a_active: assert property (p_active)
        else $error("Active flag does not follow the port select.");
    property p_idle;
        !serial_active |-> !reg_write && !reg_read;
    endproperty
    a_idle: assert property (p_idle)
        else $error("Register access while the serial port is off.");
    property p_deselect;
        serial_select_n && $past(serial_select_n) |-> !serial_out_pin_oe;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("Output driven while not selected.");
    property p_no_drive_write;
        reg_write |-> !serial_out_pin_oe;
    endproperty
    a_no_drive_write: assert property (p_no_drive_write)
        else $error("Output driven during a write.");
    property p_write_pulse;
        reg_write |=> !reg_write && $stable(reg_addr) && $stable(reg_wdata);
    endproperty
    a_write_pulse: assert property (p_write_pulse)
        else $error("Write strobe or its data misbehaves.");
    property p_read_pulse;
        reg_read |=> !reg_read && $stable(reg_addr);
    endproperty
    a_read_pulse: assert property (p_read_pulse)
        else $error("Read strobe or its address misbehaves.");
    property p_step;
        (reg_write || reg_read) && seen_ff && $past(reg_addr) == last_ff
            |-> reg_addr == (msb_first ? last_ff - 8'h01 : last_ff + 8'h01);
    endproperty
    a_step: assert property (p_step)
        else $error("Block address did not step by one.");
    property p_err_quiet;
        format_error |-> !reg_write && !reg_read && !(reg_write && reg_read);
    endproperty
    a_err_quiet: assert property (p_err_quiet)
        else $error("Register access after a bad instruction.");
    c_read: cover property (reg_read);
    c_err: cover property ($rose(format_error));
    c_block: cover property (reg_write && seen_ff);
endmodule : port_rules
bind serial_config_port port_rules chk_u (
    .clock(clock), .reset_n(reset_n), .config_port_select(config_port_select),
    .serial_select_n(serial_select_n), .msb_first(msb_first),
    .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .serial_active(serial_active), .transfer_busy(transfer_busy),
    .format_error(format_error)
);
`default_nettype wire

/* File: tb/host_model.sv */
// Behavioural serial host that frames, writes and reads bytes.
`default_nettype none
module host_model (
    input  wire logic serial_mode,
    input  wire logic msb_first,
    input  wire logic serial_out_pin,
    output var logic  serial_clock,
    output var logic  serial_select_n,
    output var logic  serial_in_pin,
    output var logic  receive_frame_sync,
    output var logic  transmit_frame_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    // The link clock only runs inside a frame, so idle time gives no stray bits.
    initial begin
        serial_clock = 1'b0;
        serial_select_n = 1'b1;
        serial_in_pin = 1'b0;
        {transmit_frame_sync, receive_frame_sync} = 2'b00;
    end
    task automatic pulse();
        #6 serial_clock = 1'b1;
        #6 serial_clock = 1'b0;
    endtask : pulse
    task automatic open_frame(input logic tx);
        serial_select_n = 1'b0;
        #5;
        if (serial_mode) begin
            {transmit_frame_sync, receive_frame_sync} = tx ? 2'b10 : 2'b01;
            pulse();
            #3 {transmit_frame_sync, receive_frame_sync} = 2'b00;
        end
    endtask : open_frame
    task automatic put(input logic [7:0] b, input int n);
        open_frame(1'b0);
        for (int i = 0; i < n; i++) begin
            serial_in_pin = msb_first ? b[7 - i] : b[i];
            pulse();
        end
        // Inverting the line after the frame keeps a stale bit from looking valid.
        serial_in_pin = ~serial_in_pin;
        #5 serial_select_n = 1'b1;
        #7;
    endtask : put
    task automatic get(output logic [7:0] b);
        open_frame(1'b1);
        for (int i = 0; i < 8; i++) begin
            #6 serial_clock = 1'b1;
            #3 b[msb_first ? 7 - i : i] = serial_out_pin;
            #3 serial_clock = 1'b0;
        end
        #5 serial_select_n = 1'b1;
        #7;
    endtask : get
endmodule : host_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the serial configuration port.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, reset_n, config_port_select, serial_mode, msb_first;
    logic        serial_clock, serial_select_n, serial_in_pin, serial_out_pin;
    logic        receive_frame_sync, transmit_frame_sync, serial_out_pin_o;
    logic        serial_out_pin_oe, reg_write, reg_read, serial_active;
    logic        transfer_busy, format_error;
    logic [7:0]  reg_rdata, reg_addr, reg_wdata;
    logic [16:0] exp_q[$];
    int          failures, checked, seed;
    initial clock = 1'b0;
    always #20 clock = ~clock;
    assign reg_rdata = reg_addr ^ 8'h5A;
    assign serial_out_pin = serial_out_pin_oe ? 1'b0 : 1'b1;
    serial_config_port dut_u (.clock(clock), .reset_n(reset_n),
        .serial_clock(serial_clock), .serial_select_n(serial_select_n),
        .serial_in_pin(serial_in_pin), .receive_frame_sync(receive_frame_sync),
        .transmit_frame_sync(transmit_frame_sync), .config_port_select(config_port_select),
        .serial_mode(serial_mode), .msb_first(msb_first), .reg_rdata(reg_rdata),
        .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .serial_active(serial_active),
        .transfer_busy(transfer_busy), .format_error(format_error));
    host_model host_u (.serial_mode(serial_mode), .msb_first(msb_first),
        .serial_out_pin(serial_out_pin), .serial_clock(serial_clock),
        .serial_select_n(serial_select_n), .serial_in_pin(serial_in_pin),
        .receive_frame_sync(receive_frame_sync), .transmit_frame_sync(transmit_frame_sync));
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // Outputs are looked at mid-cycle, away from the edge that launches them.
    always @(negedge clock) begin
        if (reg_write === 1'b1 || reg_read === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({1'b1, reg_addr, reg_wdata}, 17'h00000);
            end else begin
                check({reg_read, reg_addr, reg_read ? 8'h00 : reg_wdata},
                      exp_q.pop_front());
            end
        end
    end
    task automatic txn(input logic [7:0] addr, input logic rd, input logic [6:0] n);
        logic [7:0] a;
        logic [7:0] b;
        a = addr;
        host_u.put(addr, 8);
        host_u.put({rd, n}, 8);
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            exp_q.push_back({rd, a, rd ? 8'h00 : b});
            if (rd) begin
                // The core needs time to fetch each read byte before it is shifted.
                #400;
                check({16'h0000, transfer_busy}, 17'h00001);
                host_u.get(b);
                check({9'h000, b}, {9'h000, a ^ 8'h5A});
            end else begin
                host_u.put(b, 8);
            end
            a = msb_first ? a - 8'h01 : a + 8'h01;
        end
    endtask : txn
    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 200) begin
            @(posedge clock);
            k++;
        end
        if (exp_q.size() != 0) begin
            failures++;
            give_verdict();
        end
        repeat (4) @(posedge clock);
        check({16'h0000, transfer_busy}, 17'h00000);
    endtask : drain
    initial begin
        int k;
        seed = 32'hc73e;
        failures = 0;
        checked = 0;
        reset_n = 1'b0;
        config_port_select = 1'b1;
        serial_mode = 1'b0;
        msb_first = 1'b0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (6) @(posedge clock);
        check({16'h0000, serial_active}, 17'h00001);
        for (int m = 0; m < 4; m++) begin
            serial_mode <= m[1];
            msb_first <= m[0];
            repeat (2) @(posedge clock);
            txn(8'($random(seed)), 1'b0, 7'h03);
            txn(8'hFF ^ {8{m[0]}}, 1'b0, 7'h02);
            txn(8'($random(seed)), 1'b1, 7'h02);
            txn(8'h10, 1'b1, 7'h01);
            drain();
        end
        host_u.put(8'hC3, 3);
        txn(8'h20, 1'b0, 7'h01);
        txn(8'h40, 1'b0, 7'h7F);
        drain();
        host_u.put(8'h30, 8);
        host_u.put(8'h00, 8);
        k = 0;
        while (format_error !== 1'b1 && k < 50) begin
            @(posedge clock);
            k++;
        end
        check({16'h0000, format_error}, 17'h00001);
        txn(8'h31, 1'b0, 7'h01);
        drain();
        check({16'h0000, format_error}, 17'h00000);
        config_port_select <= 1'b0;
        repeat (6) @(posedge clock);
        check({16'h0000, serial_active}, 17'h00000);
        host_u.put(8'h50, 8);
        host_u.put(8'h01, 8);
        host_u.put(8'hAA, 8);
        repeat (20) @(posedge clock);
        config_port_select <= 1'b1;
        repeat (6) @(posedge clock);
        txn(8'h60, 1'b0, 7'h01);
        drain();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
